// File: rtl/tap_pkg.sv
// Constants for the memory test access port.
package tap_pkg;

  // ----------------------------------------
  // Register widths
  // ----------------------------------------
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_W = 107;
  localparam int DQ_W = 8;

  // ----------------------------------------
  // Instruction codes
  // ----------------------------------------
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INS_SAMPLE_PRELOAD = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;

  // Fixed capture pattern of the instruction register (low two bits 01).
  localparam logic [2:0] IR_CAPTURE = 3'h1;

  // ----------------------------------------
  // Identification fields (values are arbitrary)
  // ----------------------------------------
  localparam logic [3:0] ID_REV = 4'h0;
  localparam logic [15:0] ID_PART = 16'h0abc;
  localparam logic [10:0] ID_MAKER = 11'h05a;
  localparam logic [31:0] ID_VALUE = {ID_REV, ID_PART, ID_MAKER, 1'b1};

  // ----------------------------------------
  // Controller states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR,
    ST_EX2_IR, ST_UPD_IR
  } tap_state_t;

endpackage

// File: rtl/sram_tap.sv
// Test access port of the memory chip, oversampling the test clock.
// Function
// R1 - Sample inputs on rise, launch outputs on fall; ring_out, extest_drive and dq_float change after the rise
// R2 - Serial out shows selected register, falling-edge updates
// R3 - Mode select alone steers the controller
// R4 - Selected register from state and instruction
// R5 - No separate test reset pin exists
// R6 - Five high mode-select edges reach reset
// R7 - Power-up reset forces controller reset
// R8 - Only a restricted instruction subset exists
// R9 - Reset loads identification instruction
// R10 - 32-bit identification captured, then shifted
// R11 - Bypass is one single-bit stage
// R12 - Float-and-sample floats data pins, boundary shifts
// R13 - Standard sixteen-state controller sequence
`timescale 1ns/1ns
`default_nettype none

module sram_tap
  import tap_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [BSR_W-1:0] ring_in,
  output logic [BSR_W-1:0] ring_out,
  output logic extest_drive,
  output logic dq_float
);

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  // The test clock runs far slower than clk, so it is treated as a plain
  // input; a third stage gives a clean edge detector after the pair.
  logic [1:0] tck_s_ff, tms_s_ff, tdi_s_ff;
  logic tck_d_ff;
  // The memory ring levels come from another clock as well and pass the same pair.
  logic [BSR_W-1:0] ring_s1_ff, ring_s2_ff;

  always_ff @(posedge clk)
  begin
    tck_s_ff <= {tck_s_ff[0], tck};
    tms_s_ff <= {tms_s_ff[0], tms};
    tdi_s_ff <= {tdi_s_ff[0], tdi};
    tck_d_ff <= tck_s_ff[1];
    ring_s1_ff <= ring_in;
    ring_s2_ff <= ring_s1_ff;
  end

  wire rise = tck_s_ff[1] & ~tck_d_ff;
  wire fall = ~tck_s_ff[1] & tck_d_ff;
  wire tms_v = tms_s_ff[1];
  wire tdi_v = tdi_s_ff[1];

  // ----------------------------------------
  // Controller
  // ----------------------------------------
  tap_state_t state_ff, nxt_state;

  always_comb
  begin
    case (state_ff) // [R13]
      ST_RESET: nxt_state = tms_v ? ST_RESET : ST_IDLE;
      ST_IDLE: nxt_state = tms_v ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: nxt_state = tms_v ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nxt_state = tms_v ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: nxt_state = tms_v ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nxt_state = tms_v ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: nxt_state = tms_v ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: nxt_state = tms_v ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: nxt_state = tms_v ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: nxt_state = tms_v ? ST_RESET : ST_CAP_IR; // [R6]
      ST_CAP_IR: nxt_state = tms_v ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: nxt_state = tms_v ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nxt_state = tms_v ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: nxt_state = tms_v ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: nxt_state = tms_v ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: nxt_state = tms_v ? ST_SEL_DR : ST_IDLE;
      default: nxt_state = ST_RESET;
    endcase
  end

  // Power-up reset comes through resetn; there is no test reset pin.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      state_ff <= ST_RESET; // [R7] [R5]
    else if (rise)
      state_ff <= nxt_state; // [R3] [R1]
  end

  // ----------------------------------------
  // Instruction register
  // ----------------------------------------
  logic [IR_W-1:0] ir_sh_ff, ir_ff;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      ir_ff <= INS_IDCODE; // [R9]
    // Loading on the edge that enters reset keeps the pin controls moving only
    // after a rising test-clock edge, like every other instruction change.
    else if (state_ff == ST_RESET || (rise && nxt_state == ST_RESET))
      ir_ff <= INS_IDCODE; // [R9]
    else if (rise && state_ff == ST_UPD_IR)
      ir_ff <= ir_sh_ff;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      ir_sh_ff <= IR_CAPTURE;
    else if (rise && state_ff == ST_CAP_IR)
      ir_sh_ff <= IR_CAPTURE;
    else if (rise && state_ff == ST_SH_IR)
      ir_sh_ff <= {tdi_v, ir_sh_ff[IR_W-1:1]};
  end

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  // Reserved codes act as bypass, so only the small set is live.
  wire sel_id = (ir_ff == INS_IDCODE); // [R8]
  wire sel_bsr = (ir_ff == INS_EXTEST) || (ir_ff == INS_SAMPLE_Z) ||
    (ir_ff == INS_SAMPLE_PRELOAD);
  wire sel_byp = !sel_id && !sel_bsr; // [R8]

  // ----------------------------------------
  // Data registers
  // ----------------------------------------
  logic [ID_W-1:0] id_ff;
  logic byp_ff;
  logic [BSR_W-1:0] bsr_ff;
  logic [BSR_W-1:0] upd_ff;
  wire cap_dr = rise && state_ff == ST_CAP_DR;
  wire sh_dr = rise && state_ff == ST_SH_DR;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      id_ff <= ID_VALUE;
    else if (cap_dr && sel_id)
      id_ff <= ID_VALUE; // [R10]
    else if (sh_dr && sel_id)
      id_ff <= {tdi_v, id_ff[ID_W-1:1]}; // [R10]
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      byp_ff <= 1'b0;
    else if (cap_dr && sel_byp)
      byp_ff <= 1'b0;
    else if (sh_dr && sel_byp)
      byp_ff <= tdi_v; // [R11]
  end

  // Ring levels are synchronised first; results are still only repeatable
  // if the memory pins are held still around the capture.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      bsr_ff <= '0;
    else if (cap_dr && sel_bsr)
      bsr_ff <= ring_s2_ff;
    else if (sh_dr && sel_bsr)
      bsr_ff <= {tdi_v, bsr_ff[BSR_W-1:1]}; // [R12]
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      upd_ff <= '0;
    else if (rise && state_ff == ST_UPD_DR && sel_bsr)
      upd_ff <= bsr_ff;
  end

  // ----------------------------------------
  // Serial output, launched on the falling edge
  // ----------------------------------------
  wire in_sh_dr = (state_ff == ST_SH_DR);
  wire in_sh_ir = (state_ff == ST_SH_IR);
  wire dr_bit = sel_id ? id_ff[0] : (sel_bsr ? bsr_ff[0] : byp_ff); // [R4]
  wire nxt_tdo = in_sh_ir ? ir_sh_ff[0] : dr_bit; // [R4]

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (fall)
    begin
      tdo <= nxt_tdo; // [R2] [R1]
      tdo_oe <= in_sh_dr || in_sh_ir; // [R2]
    end
  end

  // ----------------------------------------
  // Pin control outputs
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ring_out <= '0;
      extest_drive <= 1'b0;
      dq_float <= 1'b0;
    end
    else
    begin
      ring_out <= upd_ff;
      extest_drive <= (ir_ff == INS_EXTEST);
      dq_float <= (ir_ff == INS_SAMPLE_Z); // [R12]
    end
  end

endmodule
`default_nettype wire

// File: verif/sram_tap_sva.sv
// Checker of the test port pin timing.
`timescale 1ns/1ns
`default_nettype none
module sram_tap_sva
  import tap_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [BSR_W-1:0] ring_in,
  input wire logic [BSR_W-1:0] ring_out,
  input wire logic extest_drive,
  input wire logic dq_float
);
  logic tck_ff;
  logic [2:0] ones_ff;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Saturates at five so the reset watch fires once per run of five or more high mode bits.
  always_ff @(posedge clk)
  begin
    tck_ff <= tck;
    if (!resetn || (tck && !tck_ff && !tms))
      ones_ff <= 3'h0;
    else if (tck && !tck_ff && ones_ff != 3'h5)
      ones_ff <= ones_ff + 3'h1;
  end
  a_reset_quiet: assert property (disable iff (1'h0) !resetn |=> !tdo_oe && !dq_float)
    else $error("reset");
  a_tdo_fall: assert property ($changed(tdo) |-> $past(tck, 6) && !$past(tck, 3))
    else $error("tdo edge");
  a_oe_fall: assert property ($changed(tdo_oe) |-> $past(tck, 6) && !$past(tck, 3))
    else $error("oe edge");
  a_one_mode: assert property (!(dq_float && extest_drive)) else $error("modes");
  a_ring_rise: assert property ($changed(ring_out) |-> $past(tck)) else $error("ring");
  a_float_rise: assert property ($changed(dq_float) |-> $past(tck)) else $error("float");
  a_drive_rise: assert property ($changed(extest_drive) |-> $past(tck)) else $error("drv");
  a_five_ones: assert property ($rose(ones_ff == 3'h5) |-> ##[1:6] !dq_float)
    else $error("five");
  c_float: cover property ($rose(dq_float));
  c_drive: cover property ($rose(extest_drive));
  c_five: cover property ($rose(ones_ff == 3'h5));
endmodule
bind sram_tap sram_tap_sva sva_u (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi),
  .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_out(ring_out),
  .extest_drive(extest_drive), .dq_float(dq_float));
`default_nettype wire

// File: verif/jtag_host.sv
// Model of the board tester driving the scan pins.
`timescale 1ns/1ns
`default_nettype none
module jtag_host
  import tap_pkg::*;
(
  input wire logic clk,
  input wire logic tdo,
  input wire logic tdo_oe,
  output logic tck = 1'h1,
  output logic tms = 1'h1,
  output logic tdi = 1'h1
);
  logic seen = 1'h0;
  // Mode and data move with the fall, so they are settled well before the rise.
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge clk);
    tck <= 1'h0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'h1;
    repeat (3) @(posedge clk);
    #1 seen = tdo_oe ? tdo : !seen;
    o = seen;
  endtask
  task automatic to_reset();
    logic o;
    repeat (5) step(1'h1, 1'h1, o);
  endtask
  task automatic scan(input logic ir, input int n, input logic [BSR_W-1:0] din,
      output logic [BSR_W-1:0] dout);
    logic o;
    dout = '0;
    step(1'h0, 1'h1, o);
    step(1'h1, 1'h1, o);
    if (ir)
      step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
    step(1'h0, 1'h1, o);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
  endtask
endmodule
`default_nettype wire

// File: verif/sram_tap_test.sv
// Self-checking bench for the memory test port.
`timescale 1ns/1ns
`default_nettype none
module sram_tap_test
  import tap_pkg::*;
;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic tck, tms, tdi, tdo, tdo_oe, extest_drive, dq_float;
  logic [BSR_W-1:0] ring_in = '0, ring_out, dout;
  int fail_count = 0, tests_run = 0, cycles = 0;
  always #25 clk = !clk;
  sram_tap dut_u (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_out(ring_out), .extest_drive(extest_drive),
    .dq_float(dq_float));
  jtag_host host_u (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi));
  task automatic check(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'h1)
    begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      fail_count++;
      conclude();
    end
  end
  task automatic t_idcode();
    host_u.scan(1'h0, ID_W, '0, dout);
    check(dout[ID_W-1:0] === ID_VALUE, "id");
  endtask
  task automatic t_codes();
    for (int c = 0; c < 8; c++)
    begin
      host_u.scan(1'h1, IR_W, BSR_W'(c), dout);
      repeat (2) @(posedge clk);
      check(dout[IR_W-1:0] === IR_CAPTURE, "ir");
      check(extest_drive === (c == 0) && dq_float === (c == 2), "mode");
    end
  endtask
  task automatic t_bypass(input logic [2:0] code);
    host_u.scan(1'h1, IR_W, BSR_W'(code), dout);
    host_u.scan(1'h0, 4, BSR_W'(4'hb), dout);
    check(dout[3:0] === 4'h6, "bypass");
  endtask
  task automatic t_ring(input logic [2:0] code, input logic upd);
    host_u.scan(1'h1, IR_W, BSR_W'(code), dout);
    host_u.scan(1'h0, BSR_W, ring_in ^ BSR_W'(code + 3'h1), dout);
    repeat (2) @(posedge clk);
    check(dout === ring_in, "capture");
    check(!upd || ring_out === (ring_in ^ BSR_W'(code + 3'h1)), "update");
  endtask
  task automatic t_abort();
    logic o;
    host_u.scan(1'h1, IR_W, BSR_W'(INS_SAMPLE_Z), dout);
    host_u.step(1'h1, 1'h0, o);
    host_u.step(1'h0, 1'h0, o);
    host_u.step(1'h0, 1'h0, o);
    host_u.step(1'h0, 1'h0, o);
    host_u.to_reset();
    repeat (4) @(posedge clk);
    check(dq_float === 1'h0 && tdo_oe === 1'h0, "tlr");
    t_idcode();
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    repeat (4) @(posedge clk);
    check(dq_float === 1'h0 && extest_drive === 1'h0 && ring_out === '0, "rst");
    ring_in <= BSR_W'({4{32'hc3a5_0f96}});
    t_idcode();
    t_codes();
    t_bypass(INS_BYPASS);
    t_bypass(3'h5);
    t_ring(INS_SAMPLE_Z, 1'h0);
    t_ring(INS_SAMPLE_PRELOAD, 1'h1);
    t_ring(INS_EXTEST, 1'h1);
    t_abort();
    conclude();
  end
endmodule
`default_nettype wire
